/* design/umls_top.sv */
`timescale 1ns/10ps
module umls_top import umls_pkg::*; (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [2:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  input wire logic ENH_EN,
  input wire logic IER_MODEM,
  input wire logic AUTO_CTS,
  input wire logic AUTO_RTS,
  input wire logic SW_FLOW,
  input wire logic FIFO_MODE,
  input wire umls_rxev_t RX_EV,
  input wire logic RX_LINE,
  input wire logic RX_POP,
  input wire logic RX_XON,
  input wire logic RX_XOFF,
  input wire logic TX_LOAD,
  input wire logic TX_MOVE,
  input wire logic TX_FIFO_EMPTY,
  input wire logic TX_SHIFT_BUSY,
  input wire logic CTS_N,
  input wire logic DSR_N,
  input wire logic RI_N,
  input wire logic CD_N,
  output logic RTS_N,
  output logic DTR_N,
  output logic TX_HALT,
  output logic XOFF_REQ,
  output logic XON_REQ,
  output logic BAUD_EN,
  output logic MODEM_INT,
  output logic [2:0] HEAD_TAG,
  output logic [7:0] TLR_LEVELS
);
  umls_state_t s_q, s_d;
  logic loop;
  logic alt_bank;
  logic [3:0] stat_now;
  logic [7:0] msr_val;
  logic [7:0] lsr_val;
  logic [6:0] halt_lvl;
  logic [6:0] resume_lvl;
  logic push;
  logic pop;
  logic aux_two;
  logic aux_one;
  logic [2:0] in_tag;
  logic [7:0] wmask;

  always_comb begin
    loop = s_q.ctrl[B_LOOP];
    alt_bank = ENH_EN & s_q.ctrl[B_BANK];
    aux_two = ~s_q.ctrl[B_AUX2];
    aux_one = ~s_q.ctrl[B_BANK];
    // Status order {cd, ri, dsr, cts}, active high after complementing the pins
    if (loop) begin
      stat_now = {~aux_two, ~aux_one, s_q.ctrl[B_DTR], s_q.ctrl[B_RTS]};
    end else begin
      stat_now = {~CD_N, ~RI_N, ~DSR_N, ~CTS_N};
    end
    msr_val = {s_q.stat_prev, s_q.delta};
    halt_lvl = {1'b0, s_q.flow_threshold_levels[3:0], 2'b00};
    resume_lvl = {1'b0, s_q.flow_threshold_levels[7:4], 2'b00};
    lsr_val = {(s_q.err_cnt != 7'h00),
               s_q.thre & ~TX_SHIFT_BUSY,
               s_q.thre,
               s_q.tags[s_q.rp],
               s_q.ovr,
               (s_q.cnt != 7'h00)};
    in_tag = RX_EV.tag;
    // One break character per break: further break chars are dropped until the line rises
    if (s_q.brk_hold) begin
      in_tag[TAG_BRK] = 1'b0;
    end
    pop = RX_POP & (s_q.cnt != 7'h00);
    push = RX_EV.valid & (s_q.cnt != FIFO_FULL) & ~(RX_EV.flow_char & SW_FLOW)
           & ~(s_q.brk_hold & RX_EV.tag[TAG_BRK]);
    wmask = CTRL_WMASK_BASE | (ENH_EN ? CTRL_WMASK_ENH : 8'h00);
  end

  always_comb begin
    s_d = s_q;
    // Register writes
    if (WR) begin
      if (ADDR == OFS_CTRL) begin
        s_d.ctrl = (s_q.ctrl & ~wmask) | (WDATA & wmask);
      end else if (ADDR == OFS_MSR_TCR) begin
        if (alt_bank) begin
          s_d.flow_threshold_levels = WDATA;
        end
      end else if (ADDR == OFS_SPR_TLR) begin
        if (alt_bank) begin
          s_d.fifo_trigger_levels = WDATA;
        end else begin
          s_d.scratch_byte = WDATA;
        end
      end
    end
    // Read data is captured so the port comes from a flop
    if (RD) begin
      if (ADDR == OFS_CTRL) begin
        s_d.rdata = s_q.ctrl;
      end else if (ADDR == OFS_LINE) begin
        s_d.rdata = lsr_val;
      end else if (ADDR == OFS_MSR_TCR) begin
        s_d.rdata = alt_bank ? s_q.flow_threshold_levels : msr_val;
      end else if (ADDR == OFS_SPR_TLR) begin
        s_d.rdata = alt_bank ? s_q.fifo_trigger_levels : s_q.scratch_byte;
      end else begin
        s_d.rdata = 8'h00;
      end
    end
    // Receive tag store
    if (push) begin
      s_d.tags[s_q.wp] = in_tag;
      s_d.wp = s_q.wp + 6'h01;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 6'h01;
    end
    s_d.cnt = s_q.cnt + {6'h00, push} - {6'h00, pop};
    s_d.err_cnt = s_q.err_cnt + {6'h00, push & (in_tag != 3'h0)}
                  - {6'h00, pop & (s_q.tags[s_q.rp] != 3'h0)};
    if (RX_EV.tag[TAG_BRK] & RX_EV.valid) begin
      s_d.brk_hold = 1'b1;
    end else if (RX_LINE) begin
      s_d.brk_hold = 1'b0;
    end
    // Overrun clears on a line status read, but a new overrun in that cycle wins
    if (RD & (ADDR == OFS_LINE)) begin
      s_d.ovr = 1'b0;
    end
    if (RX_EV.valid & (s_q.cnt == FIFO_FULL)) begin
      s_d.ovr = 1'b1;
    end
    // Holding-empty flag
    if (FIFO_MODE) begin
      s_d.thre = TX_FIFO_EMPTY;
    end else if (TX_LOAD) begin
      s_d.thre = 1'b0;
    end else if (TX_MOVE) begin
      s_d.thre = 1'b1;
    end
    // Modem deltas, cleared by a modem status read; a change in that cycle wins
    s_d.stat_prev = stat_now;
    if (RD & (ADDR == OFS_MSR_TCR) & ~alt_bank) begin
      s_d.delta = 4'h0;
    end
    s_d.delta[0] = s_d.delta[0] | (stat_now[0] ^ s_q.stat_prev[0]);
    s_d.delta[1] = s_d.delta[1] | (stat_now[1] ^ s_q.stat_prev[1]);
    s_d.delta[2] = s_d.delta[2] | (s_q.stat_prev[2] & ~stat_now[2]);
    s_d.delta[3] = s_d.delta[3] | (stat_now[3] ^ s_q.stat_prev[3]);
    // Receive flow hysteresis
    case (s_q.flow)
      FLOW_RUN: begin
        if ((AUTO_RTS | SW_FLOW) & (s_d.cnt >= halt_lvl)) begin
          s_d.flow = FLOW_HALT;
        end
      end
      FLOW_HALT: begin
        if (~(AUTO_RTS | SW_FLOW) | (s_d.cnt <= resume_lvl)) begin
          s_d.flow = FLOW_RUN;
        end
      end
      default: s_d.flow = FLOW_RUN;
    endcase
    // Transmit halt from received Xoff; Xon, or any char under Xon-any, resumes
    if (~SW_FLOW) begin
      s_d.sw_halt = 1'b0;
    end else if (RX_XOFF) begin
      s_d.sw_halt = 1'b1;
    end else if (RX_XON | (s_q.ctrl[B_XANY] & RX_EV.valid)) begin
      s_d.sw_halt = 1'b0;
    end
    s_d.presc = s_q.ctrl[B_PRESC] ? s_q.presc + 2'h1 : 2'h0;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
      s_q.scratch_byte <= SPR_RST;
      s_q.ctrl <= REG_RST;
      s_q.thre <= 1'b1;
      s_q.flow <= FLOW_RUN;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    RDATA = s_q.rdata;
    // Loopback keeps the modem outputs parked inactive
    DTR_N = loop | ~s_q.ctrl[B_DTR];
    RTS_N = loop | ~s_q.ctrl[B_RTS] | (AUTO_RTS & (s_q.flow == FLOW_HALT));
    // The core only samples this between characters, so the current one completes
    TX_HALT = (AUTO_CTS & ~stat_now[0]) | s_q.sw_halt;
    XOFF_REQ = SW_FLOW & (s_q.flow == FLOW_RUN) & (s_d.flow == FLOW_HALT);
    XON_REQ = SW_FLOW & (s_q.flow == FLOW_HALT) & (s_d.flow == FLOW_RUN);
    BAUD_EN = ~s_q.ctrl[B_PRESC] | (s_q.presc == PRESC_LAST);
    MODEM_INT = IER_MODEM & (s_q.delta != 4'h0);
    HEAD_TAG = s_q.tags[s_q.rp];
    TLR_LEVELS = s_q.fifo_trigger_levels;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  chk_map_tcr_read: assert property (RD && ADDR == OFS_MSR_TCR && ENH_EN && s_q.ctrl[B_BANK]
    |=> RDATA == $past(s_q.flow_threshold_levels)) else $error("offset 6 did not return thresholds");
  chk_map_spr_read: assert property (RD && ADDR == OFS_SPR_TLR && !ENH_EN
    |=> RDATA == $past(s_q.scratch_byte)) else $error("offset 7 did not return scratch");
  chk_loop_ri_src: assert property (s_q.ctrl[B_LOOP] |=> s_q.stat_prev[2] == $past(s_q.ctrl[B_BANK]))
    else $error("loopback ring source wrong");
  chk_loop_cts_src: assert property (s_q.ctrl[B_LOOP] |=> s_q.stat_prev[0] == $past(s_q.ctrl[B_RTS]))
    else $error("loopback cts source wrong");
  chk_ctrl_enh_lock: assert property (!ENH_EN |=> s_q.ctrl[B_PRESC] == $past(s_q.ctrl[B_PRESC]))
    else $error("prescaler changed without enhanced enable");
  chk_xany_lock: assert property (!ENH_EN |=> s_q.ctrl[B_XANY] == $past(s_q.ctrl[B_XANY]))
    else $error("xon-any changed without enhanced enable");
  chk_presc_rate: assert property (s_q.ctrl[B_PRESC] && $past(s_q.ctrl[B_PRESC]) && BAUD_EN
    |-> !$past(BAUD_EN)) else $error("divide by four produced back to back enables");
  chk_ready_flag: assert property (lsr_val[0] == (s_q.cnt != 7'h00))
    else $error("data ready disagrees with count");
  chk_overrun_drop: assert property (RX_EV.valid && s_q.cnt == FIFO_FULL
    |=> s_q.ovr && s_q.wp == $past(s_q.wp)) else $error("full fifo accepted a char");
  chk_err_flag: assert property (RX_EV.valid && s_q.cnt == 7'h00 && !RX_POP && RX_EV.tag[TAG_FE]
    |=> lsr_val[7] && lsr_val[3]) else $error("error tag lost");
  chk_idle_flag: assert property (TX_SHIFT_BUSY |-> !lsr_val[6])
    else $error("idle while shifting");
  chk_thre_load: assert property (!FIFO_MODE && TX_LOAD |=> !s_q.thre)
    else $error("holding empty not cleared by load");
  chk_ri_delta: assert property (!s_q.ctrl[B_LOOP] && $rose(RI_N) && !$past(RD)
    |=> s_q.delta[2]) else $error("ring end not flagged");
  chk_delta_clear: assert property (RD && ADDR == OFS_MSR_TCR && !alt_bank && stat_now == s_q.stat_prev
    |=> s_q.delta == 4'h0) else $error("modem status read did not clear deltas");
  chk_modem_int: assert property (IER_MODEM && s_q.delta[0] |-> MODEM_INT)
    else $error("modem interrupt missing");
  chk_cts_halt: assert property (AUTO_CTS && !s_q.ctrl[B_LOOP] && CTS_N |-> TX_HALT)
    else $error("cts high did not halt");
  chk_rts_halt: assert property (AUTO_RTS && s_q.ctrl[B_RTS] && !s_q.ctrl[B_LOOP]
    && s_q.cnt >= halt_lvl |=> ##1 RTS_N) else $error("rts not dropped at halt level");
  chk_rts_resume: assert property (AUTO_RTS && s_q.flow == FLOW_HALT && s_d.cnt <= resume_lvl
    |=> s_q.flow == FLOW_RUN) else $error("flow not resumed");
  chk_aux_two: assert property (s_q.ctrl[B_LOOP] |=> s_q.stat_prev[3] == $past(s_q.ctrl[B_AUX2]))
    else $error("aux two level wrong");
  chk_head_parity: assert property (lsr_val[2] == s_q.tags[s_q.rp][TAG_PE])
    else $error("parity tag not from head");
  chk_break_once: assert property (s_q.brk_hold && RX_EV.valid && RX_EV.tag[TAG_BRK]
    |=> s_q.wp == $past(s_q.wp)) else $error("second break char stored");

  cov_overrun: cover property (RX_EV.valid && s_q.cnt == FIFO_FULL);
  cov_loop_ring: cover property (s_q.ctrl[B_LOOP] && s_q.delta[2]);
  cov_xoff_xon: cover property (XOFF_REQ ##[1:200] XON_REQ);
  cov_tcr_access: cover property (WR && ADDR == OFS_MSR_TCR && alt_bank);
endmodule

/* design/umls_pkg.sv */
// Notes on behaviour
// - Offset 0x6 shows flow thresholds only when enhanced enable and bank select are 1.
// - Offset 0x7 shows trigger levels only when enhanced enable and bank select are 1.
// - In loopback the bank select bit is also the internal ring indicator.
// - Aux output two is high when its bit is 0, low when 1; loopback only.
// - Loopback bit 0 disables, 1 enables internal loopback.
// - Xon-any: any received char resumes transmit; flow chars not stored; write needs enhanced.
// - Prescaler bit 0 passes clock, 1 divides by four; write needs enhanced.
// - Data ready reads 1 while the receive FIFO holds a character.
// - Character arriving into a full FIFO sets overrun and is dropped.
// - Parity tag belongs to the character at the receive head.
// - Framing tag belongs to the character at the receive head.
// - Break flagged per break; only one break character enters the FIFO.
// - Outside FIFO mode, holding empty sets on move to shift register, clears on host load.
// - Transmitter idle only when holding store and shift register are both empty.
// - FIFO error flag is 1 while any stored byte carries an error tag.
// - CTS, DSR, CD deltas set on change; enabled deltas raise modem interrupt.
// - Ring delta sets only on ring pin low-to-high.
// - Auto CTS: CTS high halts after current character, low resumes.
// - Upper status bits are complemented inputs, or control bits in loopback.
// - Scratch byte holds host data, resets to 0xff.
// - Halt level is low nibble times four; count at or above halts flow.
// - Resume level is high nibble times four; count at or below resumes flow.
// - RTS bit 0 drives pin high, 1 low; feeds CTS status in loopback.
package umls_pkg;
  localparam logic [2:0] OFS_CTRL = 3'h4;
  localparam logic [2:0] OFS_LINE = 3'h5;
  localparam logic [2:0] OFS_MSR_TCR = 3'h6;
  localparam logic [2:0] OFS_SPR_TLR = 3'h7;
  localparam int B_DTR = 0;
  localparam int B_RTS = 1;
  localparam int B_BANK = 2;
  localparam int B_AUX2 = 3;
  localparam int B_LOOP = 4;
  localparam int B_XANY = 5;
  localparam int B_PRESC = 7;
  localparam logic [7:0] CTRL_WMASK_BASE = 8'h1f;
  localparam logic [7:0] CTRL_WMASK_ENH = 8'ha0;
  localparam logic [7:0] SPR_RST = 8'hff;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int FIFO_DEPTH = 64;
  localparam logic [6:0] FIFO_FULL = 7'h40;
  localparam logic [1:0] PRESC_LAST = 2'h3;
  localparam int TAG_PE = 0;
  localparam int TAG_FE = 1;
  localparam int TAG_BRK = 2;

  typedef enum logic [1:0] {FLOW_RUN = 2'b01, FLOW_HALT = 2'b10} umls_flow_t;

  typedef struct packed {
    logic valid;
    logic [2:0] tag;
    logic flow_char;
  } umls_rxev_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] scratch_byte;
    logic [7:0] flow_threshold_levels;
    logic [7:0] fifo_trigger_levels;
    logic [FIFO_DEPTH-1:0][2:0] tags;
    logic [5:0] wp;
    logic [5:0] rp;
    logic [6:0] cnt;
    logic [6:0] err_cnt;
    logic ovr;
    logic thre;
    logic brk_hold;
    logic [3:0] stat_prev;
    logic [3:0] delta;
    umls_flow_t flow;
    logic sw_halt;
    logic [1:0] presc;
    logic [7:0] rdata;
  } umls_state_t;
endpackage

/* dv/umls_remote.sv */
`timescale 1ns/10ps
module umls_remote import umls_pkg::*; (
  input wire logic clk,
  output umls_rxev_t rx_ev,
  output logic rx_line,
  output logic [3:0] pins_n
);
  initial begin
    rx_ev = '0;
    rx_line = 1'h1;
    pins_n = 4'hf;
  end
  // One completed character per call; valid is low for a cycle between calls
  task automatic send(input logic [2:0] tag, input logic fc);
    @(negedge clk);
    rx_ev <= '{1'h1, tag, fc};
    @(negedge clk);
    rx_ev <= '0;
  endtask
  task automatic line(input logic lvl);
    @(negedge clk);
    rx_line <= lvl;
  endtask
  // Order {cd, ri, dsr, cts}; settle time covers the status sampling delay
  task automatic pins(input logic [3:0] p);
    @(negedge clk);
    pins_n <= p;
    repeat (2) @(negedge clk);
  endtask
endmodule

/* dv/tb_top.sv */
`timescale 1ns/10ps
module tb_top import umls_pkg::*;;
  logic clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, enh = 1'h0, interrupt_enable_reg = 1'h1;
  logic acts = 1'h0, arts = 1'h0, swf = 1'h0, fmode = 1'h0, pop = 1'h0, xon = 1'h0, xoff = 1'h0;
  logic tload = 1'h0, tmove = 1'h0, tfe = 1'h1, tbusy = 1'h0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, fifo_trigger_levels;
  logic rts_n, dtr_n, thalt, baud, mint, rxl, xoff_req, xon_req;
  logic [2:0] htag;
  logic [3:0] pn;
  umls_rxev_t ev;
  int mismatches = 0, checks_done = 0, cycles = 0, n, n_xoff = 0, n_xon = 0;

  always #12.5 clk = ~clk;

  umls_top dut (
    .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WR(wr), .RD(rd), .WDATA(wdata), .RDATA(rdata),
    .ENH_EN(enh), .IER_MODEM(interrupt_enable_reg), .AUTO_CTS(acts), .AUTO_RTS(arts), .SW_FLOW(swf), .FIFO_MODE(fmode),
    .RX_EV(ev), .RX_LINE(rxl), .RX_POP(pop), .RX_XON(xon), .RX_XOFF(xoff), .TX_LOAD(tload),
    .TX_MOVE(tmove), .TX_FIFO_EMPTY(tfe), .TX_SHIFT_BUSY(tbusy), .CTS_N(pn[0]), .DSR_N(pn[1]),
    .RI_N(pn[2]), .CD_N(pn[3]), .RTS_N(rts_n), .DTR_N(dtr_n), .TX_HALT(thalt), .XOFF_REQ(xoff_req),
    .XON_REQ(xon_req), .BAUD_EN(baud), .MODEM_INT(mint), .HEAD_TAG(htag), .TLR_LEVELS(fifo_trigger_levels));

  // Flow request pulses last one cycle, so they are counted rather than sampled
  always @(posedge clk) begin
    n_xoff += int'(xoff_req);
    n_xon += int'(xon_req);
  end

  umls_remote rem (.clk(clk), .rx_ev(ev), .rx_line(rxl), .pins_n(pn));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {7'h0, exp}, {7'h0, got});
  endtask
  task automatic wrr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'h1;
    @(negedge clk);
    wr = 1'h0;
  endtask
  // Sampled a cycle late on purpose: read data holds until the next read
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'h1;
    @(negedge clk);
    rd = 1'h0;
    @(negedge clk);
    chk($sformatf("read at %h", a), exp, rdata);
  endtask
  task automatic pop_n(input int k);
    repeat (k) begin
      @(negedge clk);
      pop = 1'h1;
      @(negedge clk);
      pop = 1'h0;
    end
  endtask
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'h1;
    rdc(3'h7, 8'hff);
    rdc(3'h4, 8'h00);
    rdc(3'h5, 8'h60);
    rdc(3'h6, 8'h00);
    chk1("rts pin", 1'h1, rts_n);
    rem.pins(4'he);
    chk1("modem int", 1'h1, mint);
    interrupt_enable_reg = 1'h0;
    #1;
    chk1("modem int masked", 1'h0, mint);
    interrupt_enable_reg = 1'h1;
    #1;
    rdc(3'h6, 8'h11);
    chk1("modem int", 1'h0, mint);
    rdc(3'h6, 8'h10);
    rem.pins(4'ha);
    rdc(3'h6, 8'h50);
    rem.pins(4'he);
    rdc(3'h6, 8'h14);
    rem.pins(4'h4);
    rdc(3'h6, 8'hba);
    wrr(3'h4, 8'h1f);
    rdc(3'h6, 8'hf0);
    chk1("dtr pin", 1'h1, dtr_n);
    wrr(3'h4, 8'h17);
    rdc(3'h6, 8'h78);
    wrr(3'h4, 8'h13);
    rdc(3'h6, 8'h34);
    wrr(3'h4, 8'h03);
    rdc(3'h6, 8'hb8);
    chk1("rts pin", 1'h0, rts_n);
    chk1("dtr pin", 1'h0, dtr_n);
    rem.pins(4'hf);
    wrr(3'h7, 8'h5a);
    rdc(3'h7, 8'h5a);
    wrr(3'h4, 8'hff);
    rdc(3'h4, 8'h1f);
    enh = 1'h1;
    wrr(3'h4, 8'hff);
    rdc(3'h4, 8'hbf);
    wrr(3'h4, 8'h06);
    wrr(3'h6, 8'h2f);
    wrr(3'h7, 8'h33);
    chk("trigger levels", 8'h33, fifo_trigger_levels);
    enh = 1'h0;
    wrr(3'h6, 8'h00);
    rdc(3'h7, 8'h5a);
    enh = 1'h1;
    rdc(3'h6, 8'h2f);
    arts = 1'h1;
    repeat (59) rem.send(3'h0, 1'h0);
    chk1("rts pin", 1'h0, rts_n);
    rem.send(3'h0, 1'h0);
    chk1("rts pin", 1'h1, rts_n);
    // Fifth extra character meets a full store
    repeat (5) rem.send(3'h0, 1'h0);
    rdc(3'h5, 8'h63);
    rdc(3'h5, 8'h61);
    pop_n(55);
    chk1("rts pin", 1'h1, rts_n);
    pop_n(1);
    chk1("rts pin", 1'h0, rts_n);
    pop_n(8);
    rdc(3'h5, 8'h60);
    arts = 1'h0;
    wrr(3'h4, 8'h20);
    swf = 1'h1;
    rem.send(3'h0, 1'h1);
    rdc(3'h5, 8'h60);
    @(negedge clk);
    xoff = 1'h1;
    @(negedge clk);
    xoff = 1'h0;
    chk1("tx halt", 1'h1, thalt);
    rem.send(3'h0, 1'h0);
    chk1("tx halt", 1'h0, thalt);
    rdc(3'h5, 8'h61);
    pop_n(1);
    // Low thresholds so software flow requests show quickly: halt at 4, resume at 0
    wrr(3'h4, 8'h24);
    wrr(3'h6, 8'h01);
    repeat (4) rem.send(3'h0, 1'h0);
    chk("xoff requests", 8'h01, 8'(n_xoff));
    pop_n(4);
    chk("xon requests", 8'h01, 8'(n_xon));
    @(negedge clk);
    xoff = 1'h1;
    @(negedge clk);
    xoff = 1'h0;
    chk1("tx halt", 1'h1, thalt);
    xon = 1'h1;
    @(negedge clk);
    xon = 1'h0;
    chk1("tx halt", 1'h0, thalt);
    swf = 1'h0;
    wrr(3'h4, 8'h80);
    n = 0;
    repeat (8) begin
      @(negedge clk);
      n += baud;
    end
    chk("baud enables", 8'h02, 8'(n));
    wrr(3'h4, 8'h00);
    n = 0;
    repeat (8) begin
      @(negedge clk);
      n += baud;
    end
    chk("baud enables", 8'h08, 8'(n));
    enh = 1'h0;
    acts = 1'h1;
    rem.pins(4'hf);
    chk1("tx halt", 1'h1, thalt);
    rem.pins(4'he);
    chk1("tx halt", 1'h0, thalt);
    acts = 1'h0;
    rem.line(1'h0);
    rem.send(3'h4, 1'h0);
    rem.send(3'h4, 1'h0);
    rdc(3'h5, 8'hf1);
    chk("head tag", 8'h04, {5'h0, htag});
    rem.line(1'h1);
    pop_n(1);
    rdc(3'h5, 8'h60);
    rem.send(3'h1, 1'h0);
    rdc(3'h5, 8'he5);
    pop_n(1);
    rem.send(3'h0, 1'h0);
    rem.send(3'h2, 1'h0);
    rdc(3'h5, 8'he1);
    pop_n(1);
    rdc(3'h5, 8'he9);
    pop_n(1);
    rdc(3'h5, 8'h60);
    tbusy = 1'h1;
    @(negedge clk);
    tload = 1'h1;
    @(negedge clk);
    tload = 1'h0;
    rdc(3'h5, 8'h00);
    tmove = 1'h1;
    @(negedge clk);
    tmove = 1'h0;
    rdc(3'h5, 8'h20);
    tbusy = 1'h0;
    rdc(3'h5, 8'h60);
    fmode = 1'h1;
    tfe = 1'h0;
    rdc(3'h5, 8'h00);
    tfe = 1'h1;
    rdc(3'h5, 8'h60);
    final_report();
  end
endmodule
